/* core/rxl_pkg.sv */
`default_nettype none
package rxl_pkg;

  localparam int NUM_REFS = 5;
  localparam int ADDR_W = 10;

  // Register indices; each register sits at byte address four times its index.
  localparam logic [7:0] IDX_MODE = 8'h2C;
  localparam logic [7:0] IDX_REFSEL = 8'h2D;
  localparam logic [7:0] IDX_MASK = 8'h2E;
  localparam logic [7:0] IDX_RANK = 8'h40;
  localparam logic [7:0] IDX_STATUS = 8'h41;
  localparam logic [ADDR_W-1:0] ADDR_MODE = {IDX_MODE, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_REFSEL = {IDX_REFSEL, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_MASK = {IDX_MASK, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_RANK = {IDX_RANK, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_STATUS = {IDX_STATUS, 2'b00};

  // Values after reset.
  localparam logic [7:0] MODE_RST = 8'h02;
  localparam logic [7:0] REFSEL_RST = 8'h00;
  localparam logic [7:0] MASK_RST = 8'h3C;
  localparam logic [19:0] RANK_RST = 20'h43210;

  // Field positions.
  localparam int MASK_SW_LSB = 0;
  localparam int MASK_HOLD_LSB = 4;
  localparam int STAT_REF_LSB = 0;
  localparam int STAT_STATE_LSB = 4;
  localparam int STAT_AUTO_BIT = 7;
  localparam int STAT_SWF_LSB = 8;
  localparam int STAT_HOLDF_LSB = 16;
  localparam int STAT_QUAL_BIT = 24;

  // Highest legal reference code plus one.
  localparam logic [3:0] REF_CODES = 4'h5;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    MODE_MAN_NORMAL = 2'h0,
    MODE_MAN_HOLD = 2'h1,
    MODE_MAN_FREE = 2'h2,
    MODE_AUTO = 2'h3
  } rxl_mode_t;

  typedef enum logic [2:0] {
    LOOP_FREERUN = 3'h1,
    LOOP_LOCKED = 3'h2,
    LOOP_HOLDOVER = 3'h4
  } rxl_loop_t;

  // Failure indicators of one reference, in mask bit order.
  typedef struct packed {
    logic precise_frequency_monitor;
    logic guard_soak_timer;
    logic coarse_frequency_monitor;
    logic single_cycle_monitor;
  } rxl_fail_t;

  typedef struct packed {
    rxl_loop_t loop_state;
    logic [3:0] active_ref;
    logic auto_switch_en;
  } rxl_loop_out_t;

  typedef struct packed {
    rxl_mode_t mode;
    logic [3:0] refsel;
    logic [7:0] mask;
    logic [19:0] rank;
    rxl_loop_t loop;
    logic aw_got;
    logic [ADDR_W-1:0] awaddr;
    logic w_got;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } rxl_state_t;

  localparam rxl_state_t STATE_RST = '{
    mode: rxl_mode_t'(MODE_RST[1:0]),
    refsel: REFSEL_RST[3:0],
    mask: MASK_RST,
    rank: RANK_RST,
    loop: LOOP_FREERUN,
    aw_got: 1'b0,
    awaddr: '0,
    w_got: 1'b0,
    wdata: 32'h0000_0000,
    wstrb: 4'h0,
    bvalid: 1'b0,
    bresp: RESP_OKAY,
    rvalid: 1'b0,
    rresp: RESP_OKAY,
    rdata: 32'h0000_0000
  };

endpackage : rxl_pkg
`default_nettype wire

/* core/rxl_ref_select.sv */
// What this block does
// [RULE_01] Loop mode is a two-bit field resetting to manual free-run; upper bits reserved.
// [RULE_02] Mode 00 disables auto switching and follows the reference named by the select field.
// [RULE_03] In mode 00 a failed chosen reference puts the loop into holdover.
// [RULE_04] Mode 01 disables auto switching and holds the loop in holdover.
// [RULE_05] Mode 10 disables auto switching; the loop runs free.
// [RULE_06] Mode 11 enables auto switching to the best qualified reference on failure.
// [RULE_07] In mode 11 with no qualified reference the loop goes into holdover.
// [RULE_08] In mode 11 the select field is read-only and shows the automatic choice.
// [RULE_09] In mode 00 software writes the select field to pick the reference.
// [RULE_10] Select codes 0 to 4 name references 0 to 4; higher codes reserved; reset 0.
// [RULE_11] Mask bits 3:0 gate which indicators may trigger automatic switching.
// [RULE_12] Mask bits 7:4 gate which indicators may trigger automatic holdover.
// [RULE_13] A mask bit of 0 ignores that indicator; 1 lets it take part.
// [RULE_14] The failure mask resets to 0x3C.
// [RULE_15] Each reference has a four-bit rank; rank 0 is the highest.
// [RULE_16] Select writes in automatic mode are ignored and leave the choice intact.
// [RULE_17] Reserved bits read as their reset values and writes to them do nothing.
//
// The AXI4-Lite register port was decided locally.
`timescale 1ns/1ps
`default_nettype none
module rxl_ref_select
  import rxl_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  output logic awready,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [ADDR_W-1:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  input wire rxl_fail_t [NUM_REFS-1:0] ref_fail,
  output rxl_loop_out_t loop_out
);

  rxl_state_t s_r;
  rxl_state_t s_nxt;

  logic [7:0] sw_fail;
  logic [7:0] hold_fail;
  logic best_found;
  logic [3:0] best_idx;
  logic [3:0] best_rank;
  logic cur_valid;
  logic cur_sw_bad;
  logic cur_hold_bad;
  logic aw_take;
  logic w_take;
  logic aw_have;
  logic w_have;
  logic [ADDR_W-1:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;

  // An indicator counts only where its mask bit is set.
  function automatic logic mask_hit(input rxl_fail_t fail, input logic [3:0] msk);
    mask_hit = |(fail & msk); // [RULE_13]
  endfunction : mask_hit

  function automatic logic [3:0] rank_of(input logic [19:0] ranks, input int idx);
    rank_of = ranks[idx*4 +: 4];
  endfunction : rank_of

  assign awready = !s_r.aw_got && !s_r.bvalid;
  assign wready = !s_r.w_got && !s_r.bvalid;
  assign arready = !s_r.rvalid;
  assign bvalid = s_r.bvalid;
  assign bresp = s_r.bresp;
  assign rvalid = s_r.rvalid;
  assign rresp = s_r.rresp;
  assign rdata = s_r.rdata;

  assign loop_out.loop_state = s_r.loop;
  assign loop_out.active_ref = s_r.refsel;
  assign loop_out.auto_switch_en = (s_r.mode == MODE_AUTO); // [RULE_02] [RULE_04] [RULE_05] [RULE_06]

  always_comb begin
    s_nxt = s_r;
    sw_fail = 8'h00;
    hold_fail = 8'h00;
    best_found = 1'b0;
    best_idx = 4'h0;
    best_rank = 4'hF;

    // Candidates are references clear of every unmasked indicator; the lowest
    // rank wins and equal ranks go to the lower input number.
    for (int i = 0; i < NUM_REFS; i++) begin
      sw_fail[i] = mask_hit(ref_fail[i], s_r.mask[MASK_SW_LSB +: 4]); // [RULE_11]
      hold_fail[i] = mask_hit(ref_fail[i], s_r.mask[MASK_HOLD_LSB +: 4]); // [RULE_12]
      if (!sw_fail[i] && !hold_fail[i]
          && (!best_found || rank_of(s_r.rank, i) < best_rank)) begin // [RULE_15]
        best_found = 1'b1;
        best_idx = 4'(i);
        best_rank = rank_of(s_r.rank, i);
      end
    end

    cur_valid = (s_r.refsel < REF_CODES);
    cur_sw_bad = !cur_valid || sw_fail[s_r.refsel[2:0]];
    cur_hold_bad = !cur_valid || hold_fail[s_r.refsel[2:0]];

    case (s_r.mode)
      MODE_MAN_NORMAL: begin
        if (cur_hold_bad || cur_sw_bad) begin
          s_nxt.loop = LOOP_HOLDOVER; // [RULE_03]
        end else begin
          s_nxt.loop = LOOP_LOCKED; // [RULE_02]
        end
      end
      MODE_MAN_HOLD: begin
        s_nxt.loop = LOOP_HOLDOVER; // [RULE_04]
      end
      MODE_MAN_FREE: begin
        s_nxt.loop = LOOP_FREERUN; // [RULE_05]
      end
      MODE_AUTO: begin
        if (!cur_sw_bad && !cur_hold_bad) begin
          s_nxt.loop = LOOP_LOCKED;
        end else if (cur_sw_bad && best_found) begin
          s_nxt.refsel = best_idx; // [RULE_06] [RULE_08]
          s_nxt.loop = LOOP_LOCKED;
        end else begin
          s_nxt.loop = LOOP_HOLDOVER; // [RULE_07]
        end
      end
      default: begin
        s_nxt.loop = LOOP_FREERUN;
      end
    endcase

    // Write path: address and data may arrive in either order or together.
    aw_take = awvalid && awready;
    w_take = wvalid && wready;
    aw_have = s_r.aw_got || aw_take;
    w_have = s_r.w_got || w_take;
    wr_addr = s_r.aw_got ? s_r.awaddr : awaddr;
    wr_data = s_r.w_got ? s_r.wdata : wdata;
    wr_strb = s_r.w_got ? s_r.wstrb : wstrb;

    if (aw_have && w_have) begin
      s_nxt.aw_got = 1'b0;
      s_nxt.w_got = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = RESP_OKAY;
      case (wr_addr)
        ADDR_MODE: begin
          if (wr_strb[0]) begin
            s_nxt.mode = rxl_mode_t'(wr_data[1:0]); // [RULE_01] [RULE_17]
          end
        end
        ADDR_REFSEL: begin
          // Reserved codes are dropped so the loop never follows a missing input.
          if (wr_strb[0] && s_r.mode != MODE_AUTO && wr_data[3:0] < REF_CODES) begin
            s_nxt.refsel = wr_data[3:0]; // [RULE_09] [RULE_10] [RULE_16] [RULE_17]
          end
        end
        ADDR_MASK: begin
          if (wr_strb[0]) begin
            s_nxt.mask = wr_data[7:0]; // [RULE_11] [RULE_12]
          end
        end
        ADDR_RANK: begin
          if (wr_strb[0]) begin
            s_nxt.rank[7:0] = wr_data[7:0];
          end
          if (wr_strb[1]) begin
            s_nxt.rank[15:8] = wr_data[15:8];
          end
          if (wr_strb[2]) begin
            s_nxt.rank[19:16] = wr_data[19:16];
          end
        end
        ADDR_STATUS: begin
          s_nxt.bresp = RESP_OKAY;
        end
        default: begin
          s_nxt.bresp = RESP_SLVERR;
        end
      endcase
    end else begin
      if (aw_take) begin
        s_nxt.aw_got = 1'b1;
        s_nxt.awaddr = awaddr;
      end
      if (w_take) begin
        s_nxt.w_got = 1'b1;
        s_nxt.wdata = wdata;
        s_nxt.wstrb = wstrb;
      end
    end
    if (s_r.bvalid && bready) begin
      s_nxt.bvalid = 1'b0;
    end

    // Read path: data is captured at the address handshake.
    if (arvalid && arready) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp = RESP_OKAY;
      s_nxt.rdata = 32'h0000_0000;
      case (araddr)
        ADDR_MODE: begin
          s_nxt.rdata[1:0] = s_r.mode; // [RULE_17]
        end
        ADDR_REFSEL: begin
          s_nxt.rdata[3:0] = s_r.refsel; // [RULE_08]
        end
        ADDR_MASK: begin
          s_nxt.rdata[7:0] = s_r.mask;
        end
        ADDR_RANK: begin
          s_nxt.rdata[19:0] = s_r.rank;
        end
        ADDR_STATUS: begin
          s_nxt.rdata[STAT_REF_LSB +: 4] = s_r.refsel;
          s_nxt.rdata[STAT_STATE_LSB +: 3] = s_r.loop;
          s_nxt.rdata[STAT_AUTO_BIT] = (s_r.mode == MODE_AUTO);
          s_nxt.rdata[STAT_SWF_LSB +: NUM_REFS] = sw_fail[NUM_REFS-1:0];
          s_nxt.rdata[STAT_HOLDF_LSB +: NUM_REFS] = hold_fail[NUM_REFS-1:0];
          s_nxt.rdata[STAT_QUAL_BIT] = best_found;
        end
        default: begin
          s_nxt.rresp = RESP_SLVERR;
        end
      endcase
    end else if (s_r.rvalid && rready) begin
      s_nxt.rvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r <= STATE_RST; // [RULE_01] [RULE_10] [RULE_14]
    end else begin
      s_r <= s_nxt;
    end
  end

endmodule : rxl_ref_select
`default_nettype wire

/* tb/rxl_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module rxl_chk
  import rxl_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire rxl_fail_t [NUM_REFS-1:0] ref_fail,
  input wire rxl_loop_out_t loop_out
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  property p_rst; disable iff (1'b0) !aresetn |=> loop_out == 8'h20; endproperty
  property p_auto; loop_out.auto_switch_en |=> loop_out.loop_state != LOOP_FREERUN; endproperty
  property p_ref; loop_out.active_ref < REF_CODES; endproperty
  property p_keep;
    loop_out.auto_switch_en && ref_fail[loop_out.active_ref] == '0
      |=> $stable(loop_out.active_ref);
  endproperty
  property p_hot; $onehot(loop_out.loop_state); endproperty
  property p_wr; awvalid && awready && wvalid && wready |=> bvalid; endproperty
  property p_bst; bvalid |-> !awready && !wready; endproperty
  property p_rd; arvalid && arready |=> rvalid; endproperty
  a_rst: assert property (p_rst) else $error("bad reset state");
  a_auto: assert property (p_auto) else $error("auto loop runs free");
  a_ref: assert property (p_ref) else $error("reserved reference code");
  a_keep: assert property (p_keep) else $error("clean reference dropped");
  a_hot: assert property (p_hot) else $error("loop state not one-hot");
  a_wr: assert property (p_wr) else $error("no write response");
  a_bst: assert property (p_bst) else $error("write taken while busy");
  a_rd: assert property (p_rd) else $error("no read response");
  c_hold: cover property (loop_out.auto_switch_en && loop_out.loop_state == LOOP_HOLDOVER);
  c_sw: cover property (loop_out.auto_switch_en && $changed(loop_out.active_ref));
  c_man: cover property (!loop_out.auto_switch_en && loop_out.loop_state == LOOP_LOCKED);
endmodule : rxl_chk
bind rxl_ref_select rxl_chk u_chk (
  .aclk, .aresetn, .awvalid, .awready, .wvalid, .wready, .bvalid, .arvalid, .arready,
  .rvalid, .ref_fail, .loop_out
);
`default_nettype wire

/* tb/rxl_refs.sv */
`timescale 1ns/1ps
`default_nettype none
module rxl_refs
  import rxl_pkg::*;
(
  input wire logic aclk,
  input wire rxl_fail_t [NUM_REFS-1:0] want,
  output rxl_fail_t [NUM_REFS-1:0] ref_fail
);
  // The monitors report on the system clock, so indicators move one edge after a request.
  always_ff @(posedge aclk) begin
    ref_fail <= want;
  end
endmodule : rxl_refs
`default_nettype wire

/* tb/test_rx_loop_mode_ref_select.sv */
`timescale 1ns/1ps
`default_nettype none
module test_rx_loop_mode_ref_select
  import rxl_pkg::*;
;
  localparam rxl_loop_t MEXP [4] = '{LOOP_LOCKED, LOOP_HOLDOVER, LOOP_FREERUN, LOOP_LOCKED};
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb, s, f, cur;
  logic [1:0] bresp, rresp, r;
  logic [7:0] m;
  rxl_fail_t [NUM_REFS-1:0] want, ref_fail;
  rxl_loop_out_t loop_out;
  int miscompares, tests_run, cyc;
  rxl_ref_select dut (
    .aclk, .aresetn, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb,
    .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata,
    .rresp, .ref_fail, .loop_out
  );
  rxl_refs u_refs (.aclk, .want, .ref_fail);
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      results();
    end
  end
  task automatic results();
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : results
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] v);
    awaddr <= a;
    wdata <= v;
    wstrb <= 4'hF;
    {awvalid, wvalid, bready} <= 3'h7;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    r = bresp;
  endtask : wr
  task automatic rd(input logic [ADDR_W-1:0] a);
    araddr <= a;
    {arvalid, rready} <= 2'h3;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
  endtask : rd
  task automatic settle();
    repeat (3) @(posedge aclk);
  endtask : settle
  function automatic rxl_loop_t man_exp(logic [7:0] mk, logic [3:0] fl);
    return |(fl & (mk[3:0] | mk[7:4])) ? LOOP_HOLDOVER : LOOP_LOCKED;
  endfunction : man_exp
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata, wstrb, want} = '0;
    {miscompares, tests_run, cyc} = '0;
    void'($urandom(22378));
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk(loop_out, {LOOP_FREERUN, 4'h0, 1'b0});
    rd(ADDR_MODE);
    chk(d, 32'h2);
    rd(ADDR_REFSEL);
    chk(d, 32'h0);
    rd(ADDR_MASK);
    chk(d, 32'h3C);
    wr(ADDR_MODE, 32'hFC);
    chk(r, RESP_OKAY);
    rd(ADDR_MODE);
    chk(d, 32'h0);
    rd(10'h3FC);
    chk(r, RESP_SLVERR);
    chk(d, 32'h0);
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_MODE, 32'(i));
      settle();
      chk(loop_out.loop_state, MEXP[i]);
      chk(loop_out.auto_switch_en, i == 3);
    end
    want[0] <= 4'h4;
    settle();
    chk(loop_out, {LOOP_LOCKED, 4'h1, 1'b1});
    wr(ADDR_REFSEL, 32'h3);
    rd(ADDR_REFSEL);
    chk(d, 32'h1);
    want[1] <= 4'h1;
    settle();
    chk(loop_out, {LOOP_HOLDOVER, 4'h1, 1'b1});
    want[1] <= 4'h8;
    settle();
    chk(loop_out, {LOOP_LOCKED, 4'h2, 1'b1});
    want <= '1;
    settle();
    chk(loop_out, {LOOP_HOLDOVER, 4'h2, 1'b1});
    wr(ADDR_MASK, 32'h0);
    settle();
    chk(loop_out, {LOOP_LOCKED, 4'h2, 1'b1});
    wr(ADDR_MODE, 32'h0);
    cur = 4'h2;
    repeat (12) begin
      s = 4'($urandom_range(0, 15));
      m = 8'($urandom);
      f = 4'($urandom);
      if (s < REF_CODES) cur = s;
      wr(ADDR_REFSEL, 32'(s));
      wr(ADDR_MASK, 32'(m));
      want <= 20'(f) << (4 * cur);
      settle();
      chk(loop_out.active_ref, cur);
      chk(loop_out.loop_state, man_exp(m, f));
    end
    // Reverse the ranks so that the best candidate is not the lowest input number.
    wr(ADDR_RANK, 32'h01234);
    chk(r, RESP_OKAY);
    rd(ADDR_RANK);
    chk(d, 32'h01234);
    wr(ADDR_REFSEL, 32'h2);
    wr(ADDR_MASK, 32'(MASK_RST));
    want <= 20'h00800;
    wr(ADDR_MODE, 32'h3);
    settle();
    chk(loop_out, {LOOP_LOCKED, 4'h4, 1'b1});
    rd(ADDR_STATUS);
    chk(d, 32'h0100_04A4);
    wr(ADDR_STATUS, 32'hFFFF_FFFF);
    chk(r, RESP_OKAY);
    wr(10'h3FC, 32'h0);
    chk(r, RESP_SLVERR);
    wr(ADDR_MODE | 10'h1, 32'h0);
    chk(r, RESP_SLVERR);
    rd(ADDR_MODE);
    chk(d, 32'h3);
    // A second reset in mid-run must restore every register.
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk(loop_out, {LOOP_FREERUN, 4'h0, 1'b0});
    rd(ADDR_MASK);
    chk(d, 32'(MASK_RST));
    rd(ADDR_RANK);
    chk(d, 32'(RANK_RST));
    results();
  end
endmodule : test_rx_loop_mode_ref_select
`default_nettype wire
